/* core/vpd_map.vh */
// constants for the video port direction control block
// assumes one 250 MHz clock and static control bits from the host side
// Summary of operation
// - eight two-way ports, six 13-bit, two 11-bit
// - direction low: ports 1-4 in, 5-8 out
// - direction high: ports 1-4 out, 5-8 in
// - flag mode: bit 12 ports 1-3 carry flags
// - disable pin high tri-states every port
// - disable pin sampled on clock edges
// - vertical and field flags feed output mux
// - all pin timing on rising system clock edge
// - horizontal flag feeds output mux
`ifndef VPD_MAP_VH
`define VPD_MAP_VH
`define VPD_WIDE_W      13
`define VPD_NARROW_W    11
`define VPD_FLAG_BIT    12
`define VPD_WIDE_RST    13'h0000
`define VPD_NARROW_RST  11'h000
// ********************************************************
// slot masks and synchroniser reset levels
// ********************************************************
`define VPD_WIDE_MASK   13'h1fff
`define VPD_NARROW_MASK 13'h07ff
`define VPD_FLAG_MASK   13'h1000
`define VPD_VIDEO_MASK  13'h0fff
`define VPD_LINES_OFF   13'h0000
`define VPD_BANK_RST    52'h0
`define VPD_DIS_RST     1'b1
`define VPD_DIR_RST     1'b0
`define VPD_FLAG_EN_RST 1'b0
`define VPD_FLAG_RST    1'b0
`endif

/* core/vpd_port_ctrl.v */
// direction and enable control for eight two-way video data ports
// assumes the core supplies video words and flags on clk_in; control bits are static
`timescale 1ns/1ps
`include "vpd_map.vh"
module vpd_port_ctrl (
   input  wire                         clk_in,
   input  wire                         resetn_in,
   input  wire                         port_direction_in,
   input  wire                         timing_flag_output_enable_in,
   input  wire                         port_disable_pin_in,
   input  wire                         h_flag_in,
   input  wire                         v_flag_in,
   input  wire                         f_flag_in,
   input  wire [4*`VPD_WIDE_W-1:0]     core_bank_a_in,
   input  wire [4*`VPD_WIDE_W-1:0]     core_bank_b_in,
   input  wire [4*`VPD_WIDE_W-1:0]     pin_bank_a_in,
   input  wire [4*`VPD_WIDE_W-1:0]     pin_bank_b_in,
   output reg  [4*`VPD_WIDE_W-1:0]     pin_bank_a_out,
   output reg  [4*`VPD_WIDE_W-1:0]     pin_bank_a_oe_out,
   output reg  [4*`VPD_WIDE_W-1:0]     pin_bank_b_out,
   output reg  [4*`VPD_WIDE_W-1:0]     pin_bank_b_oe_out,
   output reg  [4*`VPD_WIDE_W-1:0]     video_bank_a_out,
   output reg  [4*`VPD_WIDE_W-1:0]     video_bank_b_out
);
   // ********************************************************
   // slot layout
   // ********************************************************
   // bank a = ports one to four, bank b = ports five to eight
   // each port sits in a 13-bit slot, port one or five lowest;
   // the fourth slot of each bank uses only its low 11 bits, its upper
   // two lines are never driven and always read back as zero

   // ********************************************************
   // synchroniser registers
   // ********************************************************
   reg                        dis_s1;
   reg                        dis_s2;
   reg                        dir_s1;
   reg                        dir_s2;
   reg                        flag_en_s1;
   reg                        flag_en_s2;
   reg                        h_s1;
   reg                        h_s2;
   reg                        v_s1;
   reg                        v_s2;
   reg                        f_s1;
   reg                        f_s2;
   reg [4*`VPD_WIDE_W-1:0]    pa_s1;
   reg [4*`VPD_WIDE_W-1:0]    pa_s2;
   reg [4*`VPD_WIDE_W-1:0]    pb_s1;
   reg [4*`VPD_WIDE_W-1:0]    pb_s2;

   // ********************************************************
   // control synchroniser
   // ********************************************************
   // host bits change on the host's own timing, so they are treated as
   // pins; disable resets high so no driver fights before setup
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         dis_s1     <= `VPD_DIS_RST;
         dis_s2     <= `VPD_DIS_RST;
         dir_s1     <= `VPD_DIR_RST;
         dir_s2     <= `VPD_DIR_RST;
         flag_en_s1 <= `VPD_FLAG_EN_RST;
         flag_en_s2 <= `VPD_FLAG_EN_RST;
      end else begin
         dis_s1     <= port_disable_pin_in;
         dis_s2     <= dis_s1;
         dir_s1     <= port_direction_in;
         dir_s2     <= dir_s1;
         flag_en_s1 <= timing_flag_output_enable_in;
         flag_en_s2 <= flag_en_s1;
      end
   end

   // ********************************************************
   // flag synchroniser
   // ********************************************************
   // flags lag the same-clock video words by two cycles; the core must
   // lead them if exact alignment on the port matters
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         h_s1 <= `VPD_FLAG_RST;
         h_s2 <= `VPD_FLAG_RST;
         v_s1 <= `VPD_FLAG_RST;
         v_s2 <= `VPD_FLAG_RST;
         f_s1 <= `VPD_FLAG_RST;
         f_s2 <= `VPD_FLAG_RST;
      end else begin
         h_s1 <= h_flag_in;
         h_s2 <= h_s1;
         v_s1 <= v_flag_in;
         v_s2 <= v_s1;
         f_s1 <= f_flag_in;
         f_s2 <= f_s1;
      end
   end

   // ********************************************************
   // pin read-back synchroniser
   // ********************************************************
   // every line is sampled, driven or not; the masks pick the video later
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pa_s1 <= `VPD_BANK_RST;
         pa_s2 <= `VPD_BANK_RST;
      end else begin
         pa_s1 <= pin_bank_a_in;
         pa_s2 <= pa_s1;
      end
   end

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pb_s1 <= `VPD_BANK_RST;
         pb_s2 <= `VPD_BANK_RST;
      end else begin
         pb_s1 <= pin_bank_b_in;
         pb_s2 <= pb_s1;
      end
   end

   // ********************************************************
   // decoded control
   // ********************************************************
   wire                       disabled;
   wire                       dir;
   wire                       flag_en;

   assign disabled = dis_s2;
   assign dir      = dir_s2;
   assign flag_en  = flag_en_s2;

   // ********************************************************
   // per-port drive and capture
   // ********************************************************
   genvar p;
   generate
      for (p = 0; p < 4; p = p + 1) begin : g_port
         localparam integer LO = p * `VPD_WIDE_W;
         localparam integer HI = LO + `VPD_WIDE_W - 1;
         wire [`VPD_WIDE_W-1:0] mask;
         wire                   has_flag;
         wire                   flag_bit;
         wire                   flag_on;
         wire [`VPD_WIDE_W-1:0] in_mask;
         wire [`VPD_WIDE_W-1:0] next_a_oe;
         wire [`VPD_WIDE_W-1:0] next_b_oe;
         wire [`VPD_WIDE_W-1:0] next_a_dat;
         wire [`VPD_WIDE_W-1:0] next_b_dat;
         wire [`VPD_WIDE_W-1:0] next_a_video;
         wire [`VPD_WIDE_W-1:0] next_b_video;

         // narrow slot keeps its top two lines dead in every mode
         assign mask     = (p == 3) ? `VPD_NARROW_MASK : `VPD_WIDE_MASK;
         assign has_flag = (p < 3);
         assign flag_bit = (p == 0) ? h_s2 : ((p == 1) ? v_s2 : f_s2);
         assign flag_on  = has_flag && flag_en;
         // flag line is never video input while flag mode owns it
         assign in_mask  = flag_on ? `VPD_VIDEO_MASK : mask;

         // bank a drives when direction high, bank b when low
         assign next_a_oe = disabled ? `VPD_LINES_OFF :
                            (dir ? mask : (flag_on ? `VPD_FLAG_MASK : `VPD_LINES_OFF));
         assign next_b_oe = (disabled || dir) ? `VPD_LINES_OFF : mask;

         // flag replaces bit 12 whatever the direction
         assign next_a_dat = flag_on ? {flag_bit, core_bank_a_in[LO+`VPD_FLAG_BIT-1:LO]}
                                     : (core_bank_a_in[HI:LO] & mask);
         assign next_b_dat = core_bank_b_in[HI:LO] & mask;

         // the output bank reads back zero rather than its own drive
         assign next_a_video = dir ? `VPD_LINES_OFF : (pa_s2[HI:LO] & in_mask);
         assign next_b_video = dir ? (pb_s2[HI:LO] & mask) : `VPD_LINES_OFF;

         always @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               pin_bank_a_out[HI:LO] <= `VPD_WIDE_RST;
            end else begin
               pin_bank_a_out[HI:LO] <= next_a_dat;
            end
         end

         always @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               pin_bank_a_oe_out[HI:LO] <= `VPD_WIDE_RST;
            end else begin
               pin_bank_a_oe_out[HI:LO] <= next_a_oe;
            end
         end

         always @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               pin_bank_b_out[HI:LO] <= `VPD_WIDE_RST;
            end else begin
               pin_bank_b_out[HI:LO] <= next_b_dat;
            end
         end

         always @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               pin_bank_b_oe_out[HI:LO] <= `VPD_WIDE_RST;
            end else begin
               pin_bank_b_oe_out[HI:LO] <= next_b_oe;
            end
         end

         always @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               video_bank_a_out[HI:LO] <= `VPD_WIDE_RST;
            end else begin
               video_bank_a_out[HI:LO] <= next_a_video;
            end
         end

         always @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               video_bank_b_out[HI:LO] <= `VPD_WIDE_RST;
            end else begin
               video_bank_b_out[HI:LO] <= next_b_video;
            end
         end
      end
   endgenerate
endmodule

/* tb/vpd_far_end.sv */
// far-side video logic: feeds the input bank, resolves both wires
// assumes ready_in high once control bits are settled
`timescale 1ns/1ps
module vpd_far_end(input logic clk_in, dir_in, flag_in, ready_in,
   input logic [51:0] oe_a_in, oe_b_in, drv_a_in, drv_b_in, output logic [51:0] a_out, b_out);
   logic [51:0] pat = 52'h5a5a5a5a5a5a5, me_a, me_b;
   // free lines toggle so a stale level never passes
   always @(posedge clk_in) pat <= ~pat;
   assign me_a = (ready_in && !dir_in) ? {13'h07ff, {3{flag_in ? 13'h0fff : 13'h1fff}}} : 52'h0;
   assign me_b = (ready_in && dir_in) ? {13'h07ff, {3{13'h1fff}}} : 52'h0;
   assign a_out = oe_a_in & drv_a_in | me_a & pat | ~(oe_a_in | me_a) & ~pat;
   assign b_out = oe_b_in & drv_b_in | me_b & pat | ~(oe_b_in | me_b) & ~pat;
endmodule

/* tb/vpd_port_ctrl_sva.sv */
// checker: drive enables, flag lines and data of the port block
// assumes static control inputs and a 3-edge synchroniser delay
`timescale 1ns/1ps
module vpd_port_ctrl_sva(input logic clk_in, resetn_in, port_direction_in, port_disable_pin_in,
   timing_flag_output_enable_in, h_flag_in, v_flag_in, f_flag_in,
   input logic [51:0] core_bank_b_in, pin_bank_a_out, pin_bank_a_oe_out, pin_bank_b_out,
   pin_bank_b_oe_out);
   localparam logic [51:0] FULL = {13'h07ff, {3{13'h1fff}}}, HVF = {13'h0000, {3{13'h1000}}};
   wire d = port_direction_in, g = timing_flag_output_enable_in, x = port_disable_pin_in;
   wire [51:0] oa = pin_bank_a_oe_out, ob = pin_bank_b_oe_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // four clean edges so the synchroniser holds post-reset values
   sequence s_up; resetn_in [*4]; endsequence
   sequence s_on; s_up ##0 !$past(x, 3); endsequence
   property p_a_out; s_on ##0 $past(d, 3) |-> oa == FULL; endproperty
   a_a_out: assert property (p_a_out) else $error("bank a not driven");
   property p_a_in; s_on ##0 !$past(d, 3) |-> oa == ($past(g, 3) ? HVF : 52'h0); endproperty
   a_a_in: assert property (p_a_in) else $error("bank a drive wrong");
   property p_b_out; s_on ##0 !$past(d, 3) |-> ob == FULL; endproperty
   a_b_out: assert property (p_b_out) else $error("bank b not driven");
   property p_b_in; s_up ##0 $past(d, 3) |-> ob == 52'h0; endproperty
   a_b_in: assert property (p_b_in) else $error("bank b driven as input");
   property p_off; s_up ##0 $past(x, 3) |-> oa == 52'h0 && ob == 52'h0; endproperty
   a_off: assert property (p_off) else $error("drive while disabled");
   property p_flag; s_on ##0 $past(g, 3) |-> {pin_bank_a_out[38], pin_bank_a_out[25],
      pin_bank_a_out[12]} == $past({f_flag_in, v_flag_in, h_flag_in}, 3); endproperty
   a_flag: assert property (p_flag) else $error("flag lines wrong");
   property p_narrow; oa[51:50] == 2'h0 && ob[51:50] == 2'h0; endproperty
   a_narrow: assert property (p_narrow) else $error("narrow port top driven");
   property p_data; s_on ##0 !$past(d, 3) |->
      (pin_bank_b_out & ob) == ($past(core_bank_b_in) & ob); endproperty
   a_data: assert property (p_data) else $error("bank b data wrong");
endmodule
bind vpd_port_ctrl vpd_port_ctrl_sva u_sva(.clk_in(clk_in), .resetn_in(resetn_in),
   .port_direction_in(port_direction_in), .port_disable_pin_in(port_disable_pin_in),
   .timing_flag_output_enable_in(timing_flag_output_enable_in), .h_flag_in(h_flag_in),
   .v_flag_in(v_flag_in), .f_flag_in(f_flag_in), .core_bank_b_in(core_bank_b_in),
   .pin_bank_a_out(pin_bank_a_out), .pin_bank_a_oe_out(pin_bank_a_oe_out),
   .pin_bank_b_out(pin_bank_b_out), .pin_bank_b_oe_out(pin_bank_b_oe_out));

/* tb/vpd_port_ctrl_tb.sv */
// self-checking bench for the port direction block
// assumes the far-end model resolves the wire levels
`timescale 1ns/1ps
module vpd_port_ctrl_tb;
   localparam logic [51:0] FULL = {13'h07ff, {3{13'h1fff}}}, HVF = {13'h0000, {3{13'h1000}}};
   logic clk_in = 0, resetn_in = 0, dir = 0, flag = 0, dis = 1, h = 0, v = 0, f = 0;
   logic [51:0] ca = 52'h0123456789abc, cb = 52'h0a5c3e1f70b29, wa, wb, pa, pb, oa, ob, va, vb;
   // {disable, flag, direction, bank a code, bank b code}
   logic [6:0] rows [8] = '{7'h02, 7'h40, 7'h26, 7'h60, 7'h18, 7'h50, 7'h38, 7'h70};
   int n_errors = 0, samples_checked = 0;
   always #2 clk_in = ~clk_in;
   vpd_port_ctrl DUT(.clk_in(clk_in), .resetn_in(resetn_in), .port_direction_in(dir),
      .timing_flag_output_enable_in(flag), .port_disable_pin_in(dis), .h_flag_in(h),
      .v_flag_in(v), .f_flag_in(f), .core_bank_a_in(ca), .core_bank_b_in(cb), .pin_bank_a_in(wa),
      .pin_bank_b_in(wb), .pin_bank_a_out(pa), .pin_bank_a_oe_out(oa), .pin_bank_b_out(pb),
      .pin_bank_b_oe_out(ob), .video_bank_a_out(va), .video_bank_b_out(vb));
   vpd_far_end far(.clk_in(clk_in), .dir_in(dir), .flag_in(flag), .ready_in(resetn_in),
      .oe_a_in(oa), .oe_b_in(ob), .drv_a_in(pa), .drv_b_in(pb), .a_out(wa), .b_out(wb));
   function automatic logic [51:0] m(input logic [1:0] c);
      return c == 2'h2 ? FULL : (c == 2'h1 ? HVF : 52'h0);
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic chk(input logic [51:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("errors=%0d checks=%0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #4000;
      n_errors++;
      final_report;
   end
   initial begin
      step(20);
      resetn_in = 1;
      foreach (rows[i]) begin
         {dis, flag, dir} = rows[i][6:4];
         step(5);
         chk(oa, m(rows[i][3:2]));
         chk(ob, m(rows[i][1:0]));
         if (!dis) chk(dir ? va : vb, 52'h0);
         // input bank captures the pin level of three edges ago, the inverse of now
         if (!dis) chk(dir ? vb : va, ~(dir ? wb : wa) & FULL & ~m({1'b0, flag & ~dir}));
         if (!dis) chk(dir ? pa & oa : pb & ob, (dir ? ca & ~m({1'b0, flag}) : cb) & FULL);
      end
      {dis, flag, dir, h, v, f, cb} = {6'h15, 52'h0fedcba987654};
      step(5);
      chk({49'h0, pa[38], pa[25], pa[12]}, 52'h5);
      chk(pb & FULL, cb & FULL);
      resetn_in = 0;
      step(1);
      chk(ob, 52'h0);
      resetn_in = 1;
      step(2);
      chk(ob, 52'h0);
      step(1);
      chk(ob, FULL);
      final_report;
   end
endmodule
